// >>> hw/ssdm_pkg.sv
// constants and types for the servo status display monitor
package ssdm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BOOT_SYMBOL_MS = 2000;
  localparam int unsigned BOOT_CYCLES = BOOT_SYMBOL_MS * (CLK_HZ / 1000);
  localparam int unsigned SAMPLE_US = 1000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BUCKET_MS = 1000;
  localparam int unsigned SAMPLES_PER_BUCKET = BUCKET_MS * 1000 / SAMPLE_US;
  localparam int unsigned LOAD_WINDOW_S = 15;
  localparam int unsigned LOAD_BUCKETS = LOAD_WINDOW_S * 1000 / BUCKET_MS;
  localparam int FB_UPPER = 2000000000;
  localparam int FB_LOWER = -2000000000;
  localparam int FB_SHIFT = 500000000;
  localparam int SHOW_LIMIT = 999999;
  localparam int FOLD_LOW = 100000;
  localparam int FOLD_HIGH = 10000;
  localparam int HIGH_UNIT = 100;
  localparam int SPEED_LIMIT = 5400;
  localparam int PEAK_LIMIT = 400;
  localparam logic [7:0] LINK_WAIT = 8'hab;
  localparam logic [7:0] LINK_INIT_A = 8'hac;
  localparam logic [7:0] LINK_INIT_B = 8'had;
  localparam logic [7:0] LINK_RUN = 8'hc0;
  localparam logic [4:0] DP_NEGATIVE = 5'h1e;
  typedef enum logic [3:0] {
    VIEW_TARGET, VIEW_REMAIN, VIEW_ENTRY, VIEW_FEEDBACK, VIEW_SPEED,
    VIEW_DROOP, VIEW_CMD_PULSE, VIEW_EFF_LOAD, VIEW_PEAK_LOAD, VIEW_TORQUE,
    VIEW_TURN_LOW, VIEW_TURN_HIGH, VIEW_TURN_COUNT, VIEW_LINK
  } ssdm_view_e;
  localparam ssdm_view_e VIEW_RESET = VIEW_FEEDBACK;
  typedef enum logic [1:0] {
    LINK_PH_WAIT, LINK_PH_INIT_A, LINK_PH_INIT_B, LINK_PH_RUN
  } ssdm_link_e;
endpackage

// >>> hw/ssdm_load_if.sv
// torque sample in, windowed load ratios out
`timescale 1ns/10ps
`default_nettype none
interface ssdm_load_if;
  logic [8:0] torque;
  logic [8:0] eff_pct;
  logic [8:0] peak_pct;
  modport mon(input torque, output eff_pct, output peak_pct);
  modport ctl(output torque, input eff_pct, input peak_pct);
endinterface
`default_nettype wire

// >>> hw/ssdm_load.sv
// sliding-window effective and peak load ratio
`timescale 1ns/10ps
`default_nettype none
module ssdm_load #(
  parameter int unsigned SAMPLE_CYCLES = ssdm_pkg::SAMPLE_CYCLES,
  parameter int unsigned SAMPLES_PER_BUCKET = ssdm_pkg::SAMPLES_PER_BUCKET,
  parameter int unsigned BUCKETS = ssdm_pkg::LOAD_BUCKETS
) (
  input wire logic clk,
  input wire logic resetn,
  ssdm_load_if.mon lif
);
  logic [31:0] div_reg;
  logic [31:0] nsamp_reg;
  logic [31:0] sq_acc_reg;
  logic [8:0] pk_acc_reg;
  logic [17:0] ms_reg [BUCKETS];
  logic [8:0] pk_reg [BUCKETS];
  logic [$clog2(BUCKETS)-1:0] idx_reg;
  logic [8:0] eff_reg;
  logic [8:0] peak_reg;
  logic tick;
  logic [17:0] sq;
  logic [31:0] sq_total;
  logic [8:0] pk_total;
  logic [23:0] ms_sum;
  logic [8:0] pk_max;

  function automatic logic [8:0] isqrt(input logic [17:0] x);
    logic [8:0] r;
    logic [8:0] t;
    r = '0;
    for (int i = 8; i >= 0; i--) begin
      t = r | (9'h1 << i);
      if (({9'h0, t} * {9'h0, t}) <= x) r = t;
    end
    return r;
  endfunction

  assign tick = (div_reg == 32'(SAMPLE_CYCLES - 1));
  assign sq = {9'h0, lif.torque} * {9'h0, lif.torque};
  assign sq_total = sq_acc_reg + {14'h0, sq};
  assign pk_total = (lif.torque > pk_acc_reg) ? lif.torque : pk_acc_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + 32'h1;
  end

  // one bucket per second, oldest overwritten
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nsamp_reg <= '0;
      sq_acc_reg <= '0;
      pk_acc_reg <= '0;
      idx_reg <= '0;
      for (int i = 0; i < BUCKETS; i++) begin
        ms_reg[i] <= '0;
        pk_reg[i] <= '0;
      end
    end else if (tick) begin
      if (nsamp_reg == 32'(SAMPLES_PER_BUCKET - 1)) begin
        ms_reg[idx_reg] <= 18'(sq_total / 32'(SAMPLES_PER_BUCKET));
        pk_reg[idx_reg] <= pk_total;
        idx_reg <= (idx_reg == ($clog2(BUCKETS))'(BUCKETS - 1)) ? '0 : idx_reg + 1'b1;
        nsamp_reg <= '0;
        sq_acc_reg <= '0;
        pk_acc_reg <= '0;
      end else begin
        nsamp_reg <= nsamp_reg + 32'h1;
        sq_acc_reg <= sq_total;
        pk_acc_reg <= pk_total;
      end
    end
  end

  always_comb begin
    ms_sum = '0;
    pk_max = '0;
    for (int i = 0; i < BUCKETS; i++) begin
      ms_sum = ms_sum + {6'h0, ms_reg[i]};
      if (pk_reg[i] > pk_max) pk_max = pk_reg[i];
    end
  end

  // rms of percent of rated torque, so rated reads 100
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eff_reg <= '0;
      peak_reg <= '0;
    end else begin
      eff_reg <= isqrt(18'(ms_sum / 24'(BUCKETS))); // RULE_16
      peak_reg <= (pk_max > 9'(ssdm_pkg::PEAK_LIMIT)) ? 9'(ssdm_pkg::PEAK_LIMIT) : pk_max; // RULE_17
    end
  end

  assign lif.eff_pct = eff_reg;
  assign lif.peak_pct = peak_reg;
endmodule
`default_nettype wire

// >>> hw/ssdm_top.sv
// status display monitor: counters, view selection, value folding
// Behaviour
// RULE_01 - count encoder feedback pulses into a signed cumulative counter, shown to 999999
// RULE_02 - feedback display digits restart from zero beyond 99999
// RULE_03 - set key while feedback value is shown clears its display value
// RULE_04 - internal counter above 2000000000 has 500000000 subtracted
// RULE_05 - internal counter below -2000000000 has 500000000 added
// RULE_06 - droop pulses shown within 99999, digits restarting beyond
// RULE_07 - within-turn low position shown in pulses, restarting past 99999
// RULE_08 - within-turn high position in 100 pulse units, restarting past 9999
// RULE_09 - absolute turn count shown signed, -32768 to 32767
// RULE_10 - executing table entry shown, 0 to 31
// RULE_11 - link state codes ab, ac/ad, c0 plus separate alarm stop flag
// RULE_12 - at power-on show chosen symbol 2 s then its value
// RULE_13 - selected quantity shows symbol; set key switches to value
// RULE_14 - negative feedback, droop or command pulse values light points 2 to 5
// RULE_15 - while stopped remaining view shows next feed, within 999999
// RULE_16 - effective load is rms over past 15 s, rated torque reads 100
// RULE_17 - peak load holds maximum over past 15 s, up to 400
// RULE_18 - speed shown signed, limited to 5400
// RULE_19 - mode key advances view cyclically, last wraps to first
`timescale 1ns/10ps
`default_nettype none
module ssdm_top #(
  parameter int unsigned BOOT_CYCLES = ssdm_pkg::BOOT_CYCLES,
  parameter int unsigned SAMPLE_CYCLES = ssdm_pkg::SAMPLE_CYCLES,
  parameter int unsigned SAMPLES_PER_BUCKET = ssdm_pkg::SAMPLES_PER_BUCKET,
  parameter int unsigned LOAD_BUCKETS = ssdm_pkg::LOAD_BUCKETS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fb_pulse,
  input wire logic fb_up,
  input wire logic signed [31:0] droop_count,
  input wire logic signed [31:0] cmd_pulse_sum,
  input wire logic signed [31:0] target_pos,
  input wire logic signed [31:0] remaining_dist,
  input wire logic signed [31:0] next_feed,
  input wire logic axis_stopped,
  input wire logic [4:0] table_entry,
  input wire logic signed [15:0] speed_rpm,
  input wire logic [8:0] torque_pct,
  input wire logic [31:0] turn_pos,
  input wire logic signed [15:0] turn_count,
  input wire logic [1:0] link_phase,
  input wire logic link_alarm,
  input wire logic key_set,
  input wire logic key_mode,
  input wire logic [3:0] init_view,
  output logic show_value,
  output logic [3:0] view_sel,
  output logic [19:0] disp_mag,
  output logic disp_neg,
  output logic [4:0] disp_dp,
  output logic [7:0] link_code,
  output logic link_alarm_stop,
  output logic signed [31:0] fb_count
);
  ssdm_pkg::ssdm_view_e view_reg;
  ssdm_pkg::ssdm_view_e mag_view_reg;
  logic first_reg;
  logic boot_reg;
  logic [31:0] boot_cnt_reg;
  logic show_reg;
  logic signed [31:0] fb_cnt_reg;
  logic signed [31:0] fb_cnt_next;
  logic signed [31:0] fb_disp_reg;
  logic signed [31:0] fb_disp_next;
  logic signed [31:0] step;
  logic [19:0] mag_reg;
  logic [19:0] mag_next;
  logic neg_reg;
  logic neg_next;
  logic [4:0] dp_reg;
  logic [4:0] dp_next;
  logic [7:0] link_code_reg;
  logic alarm_reg;
  logic signed [31:0] cl_val;
  logic boot_done;
  logic keys_live;
  logic fb_clear;
  ssdm_load_if lif();

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input int lim);
    if (v > lim) return lim;
    if (v < -lim) return -lim;
    return v;
  endfunction

  function automatic logic [31:0] absv(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [19:0] fold(input logic [31:0] m, input int n);
    return 20'(m % 32'(n));
  endfunction

  function automatic logic signed [31:0] sext16(input logic signed [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  ssdm_load #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .SAMPLES_PER_BUCKET(SAMPLES_PER_BUCKET),
    .BUCKETS(LOAD_BUCKETS)
  ) u_load (
    .clk(clk),
    .resetn(resetn),
    .lif(lif.mon)
  );

  assign lif.torque = torque_pct;

  // power-on: one cycle to catch the chosen view, then symbol hold
  assign boot_done = boot_reg && (boot_cnt_reg == 32'(BOOT_CYCLES - 1));
  assign keys_live = !first_reg;
  assign fb_clear = keys_live && key_set && !key_mode && show_reg &&
                    (view_reg == ssdm_pkg::VIEW_FEEDBACK);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) first_reg <= 1'b1;
    else first_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_reg <= 1'b1;
      boot_cnt_reg <= '0;
    end else if (boot_reg) begin
      if (keys_live && (key_set || key_mode)) boot_reg <= 1'b0;
      else if (boot_done) boot_reg <= 1'b0; // RULE_12
      else boot_cnt_reg <= boot_cnt_reg + 32'h1;
    end
  end

  // symbol first after every selection, value on set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      show_reg <= 1'b0;
    end else if (keys_live && key_mode) begin
      show_reg <= 1'b0; // RULE_13
    end else if (keys_live && key_set && !show_reg) begin
      show_reg <= 1'b1; // RULE_13
    end else if (boot_done) begin
      show_reg <= 1'b1; // RULE_12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      view_reg <= ssdm_pkg::VIEW_RESET;
    end else if (first_reg) begin
      if (init_view <= 4'(ssdm_pkg::VIEW_LINK)) view_reg <= ssdm_pkg::ssdm_view_e'(init_view);
      else view_reg <= ssdm_pkg::VIEW_RESET;
    end else if (key_mode) begin
      if (view_reg == ssdm_pkg::VIEW_LINK) view_reg <= ssdm_pkg::VIEW_TARGET; // RULE_19
      else view_reg <= ssdm_pkg::ssdm_view_e'(view_reg + 4'h1); // RULE_19
    end
  end

  // feedback counters: bounded internal count and a clearable display count
  always_comb begin
    step = fb_up ? 32'sh1 : -32'sh1;
    fb_cnt_next = fb_cnt_reg;
    fb_disp_next = fb_disp_reg;
    if (fb_pulse) begin
      fb_cnt_next = fb_cnt_reg + step; // RULE_01
      fb_disp_next = fb_disp_reg + step; // RULE_01
    end
    if (fb_cnt_next > ssdm_pkg::FB_UPPER) begin
      fb_cnt_next = fb_cnt_next - ssdm_pkg::FB_SHIFT; // RULE_04
    end else if (fb_cnt_next < ssdm_pkg::FB_LOWER) begin
      fb_cnt_next = fb_cnt_next + ssdm_pkg::FB_SHIFT; // RULE_05
    end
    if (absv(fb_disp_next) > 32'(ssdm_pkg::SHOW_LIMIT)) fb_disp_next = '0; // RULE_01
    if (fb_clear) fb_disp_next = '0; // RULE_03
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fb_cnt_reg <= '0;
      fb_disp_reg <= '0;
    end else begin
      fb_cnt_reg <= fb_cnt_next;
      fb_disp_reg <= fb_disp_next;
    end
  end

  // value for the selected view, folded or limited to its digit range
  always_comb begin
    mag_next = '0;
    neg_next = 1'b0;
    dp_next = '0;
    cl_val = '0;
    case (view_reg)
      ssdm_pkg::VIEW_TARGET: begin
        cl_val = clamp(target_pos, ssdm_pkg::SHOW_LIMIT);
        mag_next = 20'(absv(cl_val));
        neg_next = cl_val[31];
      end
      ssdm_pkg::VIEW_REMAIN: begin
        if (axis_stopped) cl_val = clamp(next_feed, ssdm_pkg::SHOW_LIMIT); // RULE_15
        else cl_val = clamp(remaining_dist, ssdm_pkg::SHOW_LIMIT);
        mag_next = 20'(absv(cl_val));
        neg_next = cl_val[31];
      end
      ssdm_pkg::VIEW_ENTRY: begin
        mag_next = {15'h0, table_entry}; // RULE_10
      end
      ssdm_pkg::VIEW_FEEDBACK: begin
        mag_next = fold(absv(fb_disp_reg), ssdm_pkg::FOLD_LOW); // RULE_02
        neg_next = fb_disp_reg[31];
        dp_next = neg_next ? ssdm_pkg::DP_NEGATIVE : 5'h00; // RULE_14
      end
      ssdm_pkg::VIEW_SPEED: begin
        cl_val = clamp(sext16(speed_rpm), ssdm_pkg::SPEED_LIMIT); // RULE_18
        mag_next = 20'(absv(cl_val));
        neg_next = cl_val[31];
      end
      ssdm_pkg::VIEW_DROOP: begin
        mag_next = fold(absv(droop_count), ssdm_pkg::FOLD_LOW); // RULE_06
        neg_next = droop_count[31];
        dp_next = neg_next ? ssdm_pkg::DP_NEGATIVE : 5'h00; // RULE_14
      end
      ssdm_pkg::VIEW_CMD_PULSE: begin
        mag_next = fold(absv(cmd_pulse_sum), ssdm_pkg::FOLD_LOW);
        neg_next = cmd_pulse_sum[31];
        dp_next = neg_next ? ssdm_pkg::DP_NEGATIVE : 5'h00; // RULE_14
      end
      ssdm_pkg::VIEW_EFF_LOAD: begin
        mag_next = {11'h0, lif.eff_pct}; // RULE_16
      end
      ssdm_pkg::VIEW_PEAK_LOAD: begin
        mag_next = {11'h0, lif.peak_pct}; // RULE_17
      end
      ssdm_pkg::VIEW_TORQUE: begin
        if (torque_pct > 9'(ssdm_pkg::PEAK_LIMIT)) mag_next = 20'(ssdm_pkg::PEAK_LIMIT);
        else mag_next = {11'h0, torque_pct};
      end
      ssdm_pkg::VIEW_TURN_LOW: begin
        mag_next = fold(turn_pos, ssdm_pkg::FOLD_LOW); // RULE_07
      end
      ssdm_pkg::VIEW_TURN_HIGH: begin
        mag_next = fold(turn_pos / 32'(ssdm_pkg::HIGH_UNIT), ssdm_pkg::FOLD_HIGH); // RULE_08
      end
      ssdm_pkg::VIEW_TURN_COUNT: begin
        cl_val = sext16(turn_count); // RULE_09
        mag_next = 20'(absv(cl_val));
        neg_next = cl_val[31];
      end
      default: begin
        mag_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mag_reg <= '0;
      neg_reg <= 1'b0;
      dp_reg <= '0;
    end else begin
      mag_reg <= mag_next;
      neg_reg <= neg_next;
      dp_reg <= dp_next;
    end
  end

  // link state code and alarm stop flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_code_reg <= ssdm_pkg::LINK_WAIT;
      alarm_reg <= 1'b0;
    end else begin
      alarm_reg <= link_alarm; // RULE_11
      case (ssdm_pkg::ssdm_link_e'(link_phase))
        ssdm_pkg::LINK_PH_WAIT: link_code_reg <= ssdm_pkg::LINK_WAIT; // RULE_11
        ssdm_pkg::LINK_PH_INIT_A: link_code_reg <= ssdm_pkg::LINK_INIT_A; // RULE_11
        ssdm_pkg::LINK_PH_INIT_B: link_code_reg <= ssdm_pkg::LINK_INIT_B; // RULE_11
        default: link_code_reg <= ssdm_pkg::LINK_RUN; // RULE_11
      endcase
    end
  end

  assign show_value = show_reg;
  assign view_sel = 4'(mag_view_reg);
  assign disp_mag = mag_reg;
  assign disp_neg = neg_reg;
  assign disp_dp = dp_reg;
  assign link_code = link_code_reg;
  assign link_alarm_stop = alarm_reg;
  assign fb_count = fb_cnt_reg;

  // view that the registered value belongs to
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) mag_view_reg <= ssdm_pkg::VIEW_RESET;
    else mag_view_reg <= view_reg;
  end

  chk_fb_upper_bound: // RULE_04
  assert property (@(posedge clk) disable iff (!resetn) fb_cnt_reg <= ssdm_pkg::FB_UPPER)
    else $error("internal feedback count above upper bound");

  chk_fb_lower_bound: // RULE_05
  assert property (@(posedge clk) disable iff (!resetn) fb_cnt_reg >= ssdm_pkg::FB_LOWER)
    else $error("internal feedback count below lower bound");

  chk_fb_digit_fold: // RULE_02
  assert property (@(posedge clk) disable iff (!resetn)
    mag_view_reg == ssdm_pkg::VIEW_FEEDBACK |-> disp_mag < 20'(ssdm_pkg::FOLD_LOW))
    else $error("feedback display not folded");

  chk_set_clears_fb: // RULE_03
  assert property (@(posedge clk) disable iff (!resetn)
    fb_clear |=> fb_disp_reg == 0 ##1 (disp_mag == 20'h00000 && !disp_neg))
    else $error("set key did not clear feedback display");

  chk_droop_digit_fold: // RULE_06
  assert property (@(posedge clk) disable iff (!resetn)
    view_reg == ssdm_pkg::VIEW_DROOP && $stable(droop_count) |=>
    disp_mag == 20'(absv($past(droop_count)) % 32'(ssdm_pkg::FOLD_LOW)))
    else $error("droop display wrong");

  chk_turn_high_fold: // RULE_08
  assert property (@(posedge clk) disable iff (!resetn)
    mag_view_reg == ssdm_pkg::VIEW_TURN_HIGH |-> disp_mag < 20'(ssdm_pkg::FOLD_HIGH))
    else $error("within-turn high display not folded");

  chk_speed_limit: // RULE_18
  assert property (@(posedge clk) disable iff (!resetn)
    mag_view_reg == ssdm_pkg::VIEW_SPEED |-> disp_mag <= 20'(ssdm_pkg::SPEED_LIMIT))
    else $error("speed display above limit");

  chk_neg_points: // RULE_14
  assert property (@(posedge clk) disable iff (!resetn)
    (mag_view_reg inside {ssdm_pkg::VIEW_FEEDBACK, ssdm_pkg::VIEW_DROOP,
     ssdm_pkg::VIEW_CMD_PULSE}) |-> (disp_dp == (disp_neg ? ssdm_pkg::DP_NEGATIVE : 5'h00)))
    else $error("negative decimal points wrong");

  chk_link_wait_code: // RULE_11
  assert property (@(posedge clk) disable iff (!resetn)
    link_phase == 2'(ssdm_pkg::LINK_PH_WAIT) |=> link_code == ssdm_pkg::LINK_WAIT)
    else $error("waiting link code wrong");

  chk_mode_wraps: // RULE_19
  assert property (@(posedge clk) disable iff (!resetn)
    keys_live && key_mode && view_reg == ssdm_pkg::VIEW_LINK |=>
    view_reg == ssdm_pkg::VIEW_TARGET && !show_value)
    else $error("mode key did not wrap to first view");

  chk_set_shows_value: // RULE_13
  assert property (@(posedge clk) disable iff (!resetn)
    keys_live && key_set && !key_mode && !show_value |=> show_value)
    else $error("set key did not show value");

  chk_entry_range: // RULE_10
  assert property (@(posedge clk) disable iff (!resetn)
    mag_view_reg == ssdm_pkg::VIEW_ENTRY |-> disp_mag <= 20'h0001f)
    else $error("table entry out of range");
endmodule
`default_nettype wire

// >>> testbench/ssdm_enc_model.sv
// encoder feedback pulse source for the status monitor bench
`timescale 1ns/10ps
`default_nettype none
module ssdm_enc_model (
  input wire logic clk,
  output logic fb_pulse,
  output logic fb_up
);
  initial begin
    fb_pulse = 1'b0;
    fb_up = 1'b0;
  end
  // back-to-back pulses; direction line inverted once released
  task automatic run(input int n, input logic up);
    repeat (n) begin
      @(negedge clk);
      fb_pulse = 1'b1;
      fb_up = up;
    end
    @(negedge clk);
    fb_pulse = 1'b0;
    fb_up = ~up;
  endtask
endmodule
`default_nettype wire

// >>> testbench/ssdm_top_tb.sv
// self-checking bench for the status display monitor
`timescale 1ns/10ps
`default_nettype none
module ssdm_top_tb;
  localparam int unsigned BOOT = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic fb_pulse, fb_up, axis_stopped, link_alarm, key_set, key_mode;
  logic signed [31:0] droop_count, cmd_pulse_sum, target_pos, remaining_dist, next_feed;
  logic [4:0] table_entry;
  logic signed [15:0] speed_rpm, turn_count;
  logic [8:0] torque_pct;
  logic [31:0] turn_pos;
  logic [1:0] link_phase;
  logic [3:0] init_view, view_sel;
  logic show_value, disp_neg, link_alarm_stop;
  logic [19:0] disp_mag;
  logic [4:0] disp_dp;
  logic [7:0] link_code;
  logic signed [31:0] fb_count;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  ssdm_top #(.BOOT_CYCLES(BOOT), .SAMPLE_CYCLES(4), .SAMPLES_PER_BUCKET(4),
    .LOAD_BUCKETS(3)) uut (.clk(clk), .resetn(resetn), .fb_pulse(fb_pulse),
    .fb_up(fb_up), .droop_count(droop_count), .cmd_pulse_sum(cmd_pulse_sum),
    .target_pos(target_pos), .remaining_dist(remaining_dist), .next_feed(next_feed),
    .axis_stopped(axis_stopped), .table_entry(table_entry), .speed_rpm(speed_rpm),
    .torque_pct(torque_pct), .turn_pos(turn_pos), .turn_count(turn_count),
    .link_phase(link_phase), .link_alarm(link_alarm), .key_set(key_set),
    .key_mode(key_mode), .init_view(init_view), .show_value(show_value),
    .view_sel(view_sel), .disp_mag(disp_mag), .disp_neg(disp_neg), .disp_dp(disp_dp),
    .link_code(link_code), .link_alarm_stop(link_alarm_stop), .fb_count(fb_count));

  ssdm_enc_model enc (.clk(clk), .fb_pulse(fb_pulse), .fb_up(fb_up));

  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("tests run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      $display("mismatch at %0t: run did not finish in time", $time);
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic press(input logic mode);
    @(negedge clk);
    key_mode = mode;
    key_set = ~mode;
    @(negedge clk);
    key_mode = 1'b0;
    key_set = 1'b0;
    @(negedge clk);
  endtask

  // step views with the mode key, then ask for the value
  task automatic goto_view(input logic [3:0] v);
    for (int i = 0; i < 14 && view_sel !== v; i++) press(1'b1);
    press(1'b0);
  endtask

  task automatic view_val(input logic [19:0] mag, input logic neg);
    tick(2);
    check({12'h0, disp_mag}, {12'h0, mag}, "shown magnitude");
    check({31'h0, disp_neg}, {31'h0, neg}, "shown sign");
  endtask

  task automatic test_boot();
    check({28'h0, view_sel}, 32'h3, "reset view");
    check({24'h0, link_code}, 32'hab, "reset link code");
    check(fb_count, 32'h0, "reset counter");
    @(negedge clk);
    resetn = 1'b1;
    tick(5);
    check({28'h0, view_sel}, 32'h4, "power-on view");
    check({31'h0, show_value}, 32'h0, "symbol first");
    tick(BOOT);
    check({31'h0, show_value}, 32'h1, "value after hold");
    $display("test boot done");
  endtask

  task automatic test_feedback();
    goto_view(4'h3);
    enc.run(5, 1'b1);
    tick(2);
    check(fb_count, 32'sd5, "count up");
    view_val(20'h5, 1'b0);
    enc.run(8, 1'b0);
    tick(2);
    check(fb_count, -32'sd3, "count down");
    view_val(20'h3, 1'b1);
    check({27'h0, disp_dp}, {27'h0, ssdm_pkg::DP_NEGATIVE}, "negative points");
    press(1'b0);
    view_val(20'h0, 1'b0);
    check(fb_count, -32'sd3, "counter kept");
    $display("test feedback done");
  endtask

  task automatic test_modes();
    logic [3:0] v;
    for (int i = 0; i < 14; i++) begin
      v = (view_sel == 4'hd) ? 4'h0 : view_sel + 4'h1;
      press(1'b1);
      check({28'h0, view_sel}, {28'h0, v}, "next view");
      check({31'h0, show_value}, 32'h0, "symbol on select");
    end
    press(1'b0);
    check({31'h0, show_value}, 32'h1, "value on set");
    $display("test modes done");
  endtask

  task automatic test_values();
    goto_view(4'h5);
    view_val(20'h5ba0, 1'b1);
    check({27'h0, disp_dp}, 32'h1e, "droop points");
    goto_view(4'h6);
    view_val(20'h7, 1'b1);
    check({27'h0, disp_dp}, 32'h1e, "command points");
    goto_view(4'ha);
    view_val(20'hb26e, 1'b0);
    goto_view(4'hb);
    view_val(20'hd80, 1'b0);
    goto_view(4'hc);
    view_val(20'h8000, 1'b1);
    goto_view(4'h0);
    view_val(20'hf423f, 1'b1);
    goto_view(4'h2);
    view_val(20'h1f, 1'b0);
    goto_view(4'h4);
    view_val(20'h1518, 1'b1);
    goto_view(4'h1);
    view_val(20'hf423f, 1'b0);
    axis_stopped = 1'b0;
    view_val(20'h5, 1'b0);
    $display("test values done");
  endtask

  task automatic test_link();
    logic [7:0] codes [4];
    codes = '{ssdm_pkg::LINK_WAIT, ssdm_pkg::LINK_INIT_A, ssdm_pkg::LINK_INIT_B,
      ssdm_pkg::LINK_RUN};
    for (int p = 0; p < 4; p++) begin
      link_phase = 2'(p);
      tick(2);
      check({24'h0, link_code}, {24'h0, codes[p]}, "link code");
    end
    link_alarm = 1'b1;
    tick(2);
    check({31'h0, link_alarm_stop}, 32'h1, "alarm stop");
    link_alarm = 1'b0;
    tick(2);
    check({31'h0, link_alarm_stop}, 32'h0, "alarm clear");
    $display("test link done");
  endtask

  task automatic test_load();
    goto_view(4'h7);
    view_val(20'h64, 1'b0);
    goto_view(4'h8);
    torque_pct = 9'd450;
    tick(80);
    view_val(20'h190, 1'b0);
    torque_pct = 9'd0;
    tick(80);
    view_val(20'h0, 1'b0);
    goto_view(4'h9);
    torque_pct = 9'd450;
    view_val(20'h190, 1'b0);
    $display("test load done");
  endtask

  initial begin
    axis_stopped = 1'b1;
    link_alarm = 1'b0;
    key_set = 1'b0;
    key_mode = 1'b0;
    droop_count = -32'sd123456;
    cmd_pulse_sum = -32'sd7;
    target_pos = -32'sd1234567;
    remaining_dist = 32'sd5;
    next_feed = 32'sd2000000;
    table_entry = 5'h1f;
    speed_rpm = -16'sd6000;
    torque_pct = 9'd100;
    turn_pos = 32'd12345678;
    turn_count = -16'sd32768;
    link_phase = 2'h0;
    init_view = 4'h4;
    tick(12);
    test_boot();
    test_feedback();
    test_modes();
    test_values();
    test_link();
    test_load();
    end_of_test();
  end
endmodule
`default_nettype wire
